// ### rtl/vsf_pkg.sv
// package for the video stream forwarding controller
// assumes one device clock and a byte-wide register port
package vsf_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] VSF_FWD_OFF_ADDR  = 8'h20;
   localparam logic [7:0] VSF_CTRL_ADDR     = 8'h21;
   localparam logic [7:0] VSF_STATUS_ADDR   = 8'h22;
   // ==========================================
   // field positions
   localparam int VSF_PORT_A_OFF_BIT = 4;
   localparam int VSF_PORT_B_OFF_BIT = 5;
   localparam int VSF_DUP_BIT        = 7;
   localparam int VSF_SWR_BIT        = 6;
   localparam int VSF_MODE_LO        = 2;
   localparam int VSF_ROT_BIT        = 0;
   localparam int VSF_LOST_BIT       = 2;
   localparam int VSF_OK_BIT         = 0;
   // ==========================================
   // reset values
   localparam logic [7:0] VSF_FWD_OFF_RST = 8'h30;
   localparam logic [7:0] VSF_CTRL_RST    = 8'h01;
   // ==========================================
   // lockstep modes
   localparam logic [1:0] VSF_MODE_OFF    = 2'h0;
   localparam logic [1:0] VSF_MODE_BASIC  = 2'h1;
   localparam logic [1:0] VSF_MODE_ILEAVE = 2'h2;
   localparam logic [1:0] VSF_MODE_CONCAT = 2'h3;
   // ==========================================
   // lockstep watchdog: lines must pair up within this many cycles
   localparam int VSF_SKEW_NS     = 20000;
   localparam int VSF_CLK_MHZ     = 200;
   localparam int VSF_SKEW_CYCLES = (VSF_SKEW_NS * VSF_CLK_MHZ) / 1000;
endpackage : vsf_pkg

// ### rtl/vsf_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module vsf_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;
   // ==========================================
   // handshakes
   assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];
   // storage, registered entries
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end
   // pointers and fill count
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : vsf_fifo

// ### rtl/vsf_forward_ctrl.sv
// forwarding engine: two receive line streams onto one csi output pair
// assumes line buffers upstream present whole words with sol/eol marks
// What this block does
// - duplicate bit set: second output carries exactly the stream of output 0
// - lockstep: hold a line until every enabled port has one ready
// - send-when-ready: forward each port's line as soon as it is ready
// - send-when-ready ignored in concatenation, never touches short packets
// - mode field 00 off, 01 basic, 10 interleave, 11 concatenate, reset zero
// - rotating forwarding (reset on) serves ready sources in turn, no sync
// - lost flag only set after one full lockstep frame was sent
// - reading status returns lost flag then clears it
// - ok bit high while lockstep delivery from all enabled ports works
// - ok bit reads zero when lockstep forwarding is off
// - per-port forward-off bits, reset one; port enabled only when zero
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module vsf_forward_ctrl #(
   parameter int DW          = 32,
   parameter int FIFO_DEPTH  = 32,
   parameter int SKEW_CYCLES = vsf_pkg::VSF_SKEW_CYCLES
) (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [7:0]    reg_rdata,
   input  wire logic [DW-1:0] a_data,
   input  wire logic          a_sol,
   input  wire logic          a_eol,
   input  wire logic          a_short,
   input  wire logic          a_fend,
   input  wire logic          a_valid,
   output logic               a_ready,
   input  wire logic [DW-1:0] b_data,
   input  wire logic          b_sol,
   input  wire logic          b_eol,
   input  wire logic          b_short,
   input  wire logic          b_fend,
   input  wire logic          b_valid,
   output logic               b_ready,
   output logic      [DW-1:0] tx0_data,
   output logic               tx0_eol,
   output logic               tx0_short,
   output logic               tx0_valid,
   output logic      [DW-1:0] tx1_data,
   output logic               tx1_eol,
   output logic               tx1_short,
   output logic               tx1_valid,
   input  wire logic          tx_ready
);
   typedef enum logic [3:0] {
      VSF_IDLE  = 4'b0001,
      VSF_SEL   = 4'b0010,
      VSF_SEND  = 4'b0100,
      VSF_WAIT  = 4'b1000
   } vsf_state_t;
   localparam int FW = DW + 2;
   localparam int CW = $clog2(SKEW_CYCLES + 1);
   logic [7:0]    fwd_off_q;
   logic [7:0]    ctrl_q;
   logic          lost_q;
   logic          ok_q;
   logic          frame_done_q;
   logic [CW-1:0] skew_q;
   vsf_state_t    st_q;
   logic          cur_q;        // port being sent: 0 = a, 1 = b
   logic          pend_q;       // concatenation: second port still due
   logic          last_q;       // rotating pointer: last served port
   logic [1:0]    owed_q;       // lockstep: ports still due in this round
   logic [1:0]    en;
   logic [1:0]    mode;
   logic          lockstep;
   logic          swr_eff;
   logic [1:0]    head_sol;
   logic [1:0]    head_short;
   logic          all_ready;
   logic          pick;
   logic          can_go;
   logic          beat;
   logic          beat_eol;
   logic [DW-1:0] o_data;
   logic          o_eol;
   logic          o_short;
   logic          o_valid;
   logic          f_ready;
   logic [FW-1:0] f_out;
   logic          f_ovalid;
   // ==========================================
   // decoded controls
   assign en       = ~{fwd_off_q[vsf_pkg::VSF_PORT_B_OFF_BIT],
                       fwd_off_q[vsf_pkg::VSF_PORT_A_OFF_BIT]};
   assign mode     = ctrl_q[vsf_pkg::VSF_MODE_LO +: 2];
   assign lockstep = (mode != vsf_pkg::VSF_MODE_OFF);
   // concatenation always waits for both lines
   assign swr_eff  = ctrl_q[vsf_pkg::VSF_SWR_BIT]
                     && (mode != vsf_pkg::VSF_MODE_CONCAT);
   assign head_sol   = {b_valid && b_sol, a_valid && a_sol};
   assign head_short = {b_valid && b_short, a_valid && a_short};
   // lockstep gate: every enabled port has a line head waiting
   assign all_ready  = ((head_sol[0] || !en[0]) && (head_sol[1] || !en[1])) && (en != 2'h0);
   // ==========================================
   // source selection, rotating when both are eligible; concatenation always picks port a first
   always_comb
   begin
      logic [1:0] elig;
      elig = {b_valid, a_valid} & en;
      if (lockstep)
      begin
         // sync packets always pair up; lines pair unless send-when-ready
         elig = elig & ((all_ready ? 2'h3 : owed_q)
                        | (swr_eff ? ~head_short : 2'h0));
      end
      if (elig == 2'h3)
      begin
         pick = (mode == vsf_pkg::VSF_MODE_CONCAT) ? 1'b0 : ~last_q;
      end
      else
      begin
         pick = elig[1];
      end
      can_go = (elig != 2'h0);
   end
   // ==========================================
   // forwarding state machine
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_q   <= VSF_IDLE;
         cur_q  <= 1'b0;
         pend_q <= 1'b0;
         last_q <= 1'b1;
      end
      else
      begin
         case (st_q)
            VSF_IDLE:
            begin
               st_q <= VSF_SEL;
            end
            VSF_SEL:
            begin
               if (can_go)
               begin
                  cur_q  <= pick;
                  last_q <= pick;
                  // concatenation: both lines join one long packet
                  pend_q <= (mode == vsf_pkg::VSF_MODE_CONCAT) && (en == 2'h3)
                            && !head_short[pick];
                  st_q   <= VSF_SEND;
               end
            end
            VSF_SEND:
            begin
               if (beat && beat_eol)
               begin
                  if (pend_q)
                  begin
                     cur_q  <= ~cur_q;
                     pend_q <= 1'b0;
                  end
                  else
                  begin
                     st_q <= VSF_WAIT;
                  end
               end
            end
            VSF_WAIT:
            begin
               st_q <= VSF_SEL;                 // two idle beats between packets, this one and VSF_SEL
            end
            default:
            begin
               st_q <= VSF_IDLE;
            end
         endcase
      end
   end
   // ==========================================
   // datapath into the output fifo; back-pressure stalls the source
   assign beat     = (st_q == VSF_SEND) && f_ready && (cur_q ? b_valid : a_valid);
   assign beat_eol = cur_q ? b_eol : a_eol;
   assign a_ready  = (st_q == VSF_SEND) && !cur_q && f_ready;
   assign b_ready  = (st_q == VSF_SEND) && cur_q && f_ready;
   assign o_data   = cur_q ? b_data : a_data;
   // first line's end is hidden while the second is still to follow
   assign o_eol    = beat_eol && !pend_q;
   assign o_short  = cur_q ? b_short : a_short;
   assign o_valid  = beat;
   vsf_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_data   ({o_short, o_eol, o_data}),
      .in_valid  (o_valid),
      .in_ready  (f_ready),
      .out_data  (f_out),
      .out_valid (f_ovalid),
      .out_ready (tx_ready)
   );
   // ==========================================
   // output 0 and its replica, registered from the fifo head
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         tx0_data  <= '0;
         tx0_eol   <= 1'b0;
         tx0_short <= 1'b0;
         tx0_valid <= 1'b0;
         tx1_data  <= '0;
         tx1_eol   <= 1'b0;
         tx1_short <= 1'b0;
         tx1_valid <= 1'b0;
      end
      else
      begin
         tx0_data  <= f_out[DW-1:0];
         tx0_eol   <= f_out[DW];
         tx0_short <= f_out[DW+1];
         tx0_valid <= f_ovalid && tx_ready;
         // replica only while duplication is on, else held quiet
         tx1_data  <= ctrl_q[vsf_pkg::VSF_DUP_BIT] ? f_out[DW-1:0] : '0;
         tx1_eol   <= ctrl_q[vsf_pkg::VSF_DUP_BIT] && f_out[DW];
         tx1_short <= ctrl_q[vsf_pkg::VSF_DUP_BIT] && f_out[DW+1];
         tx1_valid <= ctrl_q[vsf_pkg::VSF_DUP_BIT] && f_ovalid && tx_ready;
      end
   end
   // ==========================================
   // lockstep supervision: a port line waiting too long means lost sync
   always_ff @(posedge clock)
   begin
      if (sys_rst || !lockstep)
      begin
         skew_q       <= '0;
         ok_q         <= 1'b0;
         frame_done_q <= 1'b0;
         owed_q       <= 2'h0;
      end
      else
      begin
         // a paired round lets the other port follow alone, else the last line hangs
         if ((st_q == VSF_SEL) && can_go && (!swr_eff || head_short[pick]))
         begin
            owed_q <= (all_ready && (head_short[pick] || mode != vsf_pkg::VSF_MODE_CONCAT))
                      ? (en & ~{pick, !pick}) : (owed_q & ~{pick, !pick});
         end
         if ((head_sol != 2'h0) && !all_ready && (st_q == VSF_SEL))
         begin
            skew_q <= (skew_q == CW'(SKEW_CYCLES)) ? skew_q : skew_q + CW'(1);
         end
         else
         begin
            skew_q <= '0;
         end
         // ok once lines pair up, dropped when the skew runs out
         if (all_ready)
         begin
            ok_q <= 1'b1;
         end
         else if (skew_q == CW'(SKEW_CYCLES) || en == 2'h0)
         begin
            ok_q <= 1'b0;
         end
         if (ok_q && beat && o_short && (cur_q ? b_fend : a_fend))
         begin
            frame_done_q <= 1'b1;
         end
      end
   end
   // ==========================================
   // register writes
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         fwd_off_q <= vsf_pkg::VSF_FWD_OFF_RST;
         ctrl_q    <= vsf_pkg::VSF_CTRL_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == vsf_pkg::VSF_FWD_OFF_ADDR)
         begin
            fwd_off_q <= reg_wdata & 8'hf0;   // low nibble reserved, reads zero
         end
         if (reg_addr == vsf_pkg::VSF_CTRL_ADDR)
         begin
            ctrl_q <= reg_wdata & 8'hcf;      // bits 5:4 reserved, read-only
         end
      end
   end
   // lost flag: a failure event beats the clear from a read
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         lost_q <= 1'b0;
      end
      else if (lockstep && frame_done_q && ok_q && skew_q == CW'(SKEW_CYCLES))
      begin
         lost_q <= 1'b1;
      end
      else if (reg_rd && reg_addr == vsf_pkg::VSF_STATUS_ADDR)
      begin
         lost_q <= 1'b0;
      end
   end
   // read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         reg_rdata <= '0;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            vsf_pkg::VSF_FWD_OFF_ADDR: reg_rdata <= fwd_off_q;
            vsf_pkg::VSF_CTRL_ADDR:    reg_rdata <= ctrl_q;
            vsf_pkg::VSF_STATUS_ADDR:  reg_rdata <= {5'h0, lost_q, 1'b0, ok_q};
            default:                   reg_rdata <= '0;
         endcase
      end
      else
      begin
         reg_rdata <= '0;
      end
   end
endmodule : vsf_forward_ctrl

// ### test/vsf_monitor.sv
// monitor: port-level checks of the forwarding controller
// assumes it is bound onto vsf_forward_ctrl, one clock, sync reset
`timescale 1ns/1ps
module vsf_monitor #(
   parameter int DW = 32
) (
   input wire logic          clock,
   input wire logic          sys_rst,
   input wire logic [7:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   input wire logic          a_sol,
   input wire logic          a_valid,
   input wire logic          a_ready,
   input wire logic          b_sol,
   input wire logic          b_valid,
   input wire logic          b_ready,
   input wire logic [DW-1:0] tx0_data,
   input wire logic          tx0_short,
   input wire logic          tx0_valid,
   input wire logic [DW-1:0] tx1_data,
   input wire logic          tx1_valid
);
   logic [7:0] off_q;
   logic [7:0] ctl_q;
   logic       last_a_q;
   logic       sent_q;
   logic [3:0] dif_q;
   wire        st_rd  = reg_rd && reg_addr == vsf_pkg::VSF_STATUS_ADDR;
   wire        a_go   = a_valid && a_ready && a_sol;
   wire        b_go   = b_valid && b_ready && b_sol;
   wire        lk_on  = ctl_q[3:2] != 2'h0;
   wire        strict = lk_on && (!ctl_q[6] || ctl_q[3:2] == 2'h3) && off_q[5:4] == 2'h0;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // shadows of the two control registers
   always_ff @(posedge clock)
   begin
      if (sys_rst || reg_wr && reg_addr == vsf_pkg::VSF_FWD_OFF_ADDR)
         off_q <= sys_rst ? vsf_pkg::VSF_FWD_OFF_RST : reg_wdata;
      if (sys_rst || reg_wr && reg_addr == vsf_pkg::VSF_CTRL_ADDR)
         ctl_q <= sys_rst ? vsf_pkg::VSF_CTRL_RST : reg_wdata;
   end
   // line-start balance; reset outside strict lockstep since lines may run ahead there
   always_ff @(posedge clock)
   begin
      last_a_q <= sys_rst ? 1'b0 : a_go ? 1'b1 : b_go ? 1'b0 : last_a_q;
      sent_q   <= !sys_rst && (sent_q || tx0_valid && tx0_short && lk_on);
      dif_q    <= sys_rst || !strict ? 4'h0 : dif_q + 4'(a_go) - 4'(b_go);
   end
   // ==========================================
   // properties
   sequence s_rctl; reg_rd && reg_addr == vsf_pkg::VSF_CTRL_ADDR; endsequence
   property p_dup; tx1_valid |-> tx0_valid && tx1_data == tx0_data; endproperty
   a_dup: assert property (p_dup) else $error("copy output differs");
   property p_ctl; s_rctl |=> reg_rdata == ($past(ctl_q) & 8'hcf); endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   property p_off;
      (off_q[4] && $past(off_q[4]) |-> !a_ready) and (off_q[5] && $past(off_q[5]) |-> !b_ready);
   endproperty
   a_off: assert property (p_off) else $error("disabled port taken");
   property p_ok0; st_rd && !lk_on && $past(ctl_q[3:2]) == 2'h0 |=> !reg_rdata[0]; endproperty
   a_ok0: assert property (p_ok0) else $error("ok bit set with lockstep off");
   property p_early; st_rd && !sent_q |=> !reg_rdata[2]; endproperty
   a_early: assert property (p_early) else $error("lost flag before a frame");
   property p_rc; st_rd && !lk_on ##[1:4] st_rd |=> !reg_rdata[2]; endproperty
   a_rc: assert property (p_rc) else $error("lost flag not cleared by read");
   property p_lock; dif_q inside {4'h0, 4'h1, 4'hf}; endproperty
   a_lock: assert property (p_lock) else $error("port ran ahead in lockstep");
   property p_rot;
      !lk_on && ctl_q[0] && off_q[5:4] == 2'h0 && a_go && last_a_q
         |-> !($past(b_valid, 1) && $past(b_valid, 2) && $past(b_valid, 3));
   endproperty
   a_rot: assert property (p_rot) else $error("rotation skipped port b");
endmodule : vsf_monitor

bind vsf_forward_ctrl vsf_monitor #(.DW(DW)) vsf_monitor_i (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_sol(a_sol),
   .a_valid(a_valid), .a_ready(a_ready), .b_sol(b_sol), .b_valid(b_valid),
   .b_ready(b_ready), .tx0_data(tx0_data), .tx0_short(tx0_short), .tx0_valid(tx0_valid),
   .tx1_data(tx1_data), .tx1_valid(tx1_valid)
);

// ### test/vsf_sink_model.sv
// receiver model for the two transmit outputs, logs every word taken
// assumes one or two lanes per output while copying, no lane detail here
`timescale 1ns/1ps
module vsf_sink_model (
   input  wire logic        clock,
   input  wire logic        stop,
   input  wire logic        slow,
   input  wire logic [31:0] tx0_data,
   input  wire logic        tx0_eol,
   input  wire logic        tx0_short,
   input  wire logic        tx0_valid,
   input  wire logic [31:0] tx1_data,
   input  wire logic        tx1_eol,
   input  wire logic        tx1_short,
   input  wire logic        tx1_valid,
   output logic             tx_ready
);
   logic [33:0] q0[$];
   logic [33:0] q1[$];
   logic [7:0]  lfsr_q = 8'h5b;
   // ==========================================
   // accept path: lfsr stalls when slow, so the fifo sees back pressure
   always @(posedge clock)
   begin
      lfsr_q   <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      tx_ready <= !stop && (!slow || lfsr_q[0]);
      if (tx0_valid)
         q0.push_back({tx0_eol, tx0_short, tx0_data});
      if (tx1_valid)
         q1.push_back({tx1_eol, tx1_short, tx1_data});
   end
endmodule : vsf_sink_model

// ### test/testbench.sv
// testbench: drives both receive streams and the register port
// assumes the sink model and the bound monitor stand beside the design
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // signals; beats are {fend, short, eol, sol, data}
   logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        stop = 1'b0, slow = 1'b0, tx_ready, a_ready, b_ready;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [31:0] tx0_data, tx1_data;
   logic        tx0_eol, tx0_short, tx0_valid, tx1_eol, tx1_short, tx1_valid;
   logic [35:0] sq[2][$];
   logic [35:0] sb[2] = '{36'h0, 36'h0};
   logic        sv[2] = '{1'b0, 1'b0};
   logic [33:0] eq[2][$];
   int          sp[2] = '{0, 0};
   int          mismatches = 0;
   int          n_tests = 0;
   initial forever #2.5 clock = ~clock;
   vsf_forward_ctrl #(.SKEW_CYCLES(20)) vsf_forward_ctrl_i (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .a_data(sb[0][31:0]), .a_sol(sb[0][32]), .a_eol(sb[0][33]), .a_short(sb[0][34]),
      .a_fend(sb[0][35]), .a_valid(sv[0]), .a_ready(a_ready),
      .b_data(sb[1][31:0]), .b_sol(sb[1][32]), .b_eol(sb[1][33]), .b_short(sb[1][34]),
      .b_fend(sb[1][35]), .b_valid(sv[1]), .b_ready(b_ready),
      .tx0_data(tx0_data), .tx0_eol(tx0_eol), .tx0_short(tx0_short), .tx0_valid(tx0_valid),
      .tx1_data(tx1_data), .tx1_eol(tx1_eol), .tx1_short(tx1_short), .tx1_valid(tx1_valid),
      .tx_ready(tx_ready));
   vsf_sink_model vsf_sink_model_i (
      .clock(clock), .stop(stop), .slow(slow), .tx0_data(tx0_data), .tx0_eol(tx0_eol),
      .tx0_short(tx0_short), .tx0_valid(tx0_valid), .tx1_data(tx1_data), .tx1_eol(tx1_eol),
      .tx1_short(tx1_short), .tx1_valid(tx1_valid), .tx_ready(tx_ready));
   // ==========================================
   // stream drivers: a beat stands until taken; idle data shows its inverse
   always @(posedge clock)
      for (int p = 0; p < 2; p++)
      begin
         if (sv[p] && (p == 0 ? a_ready : b_ready))
            sp[p]++;
         sv[p] <= sp[p] < sq[p].size();
         sb[p] <= sp[p] < sq[p].size() ? sq[p][sp[p]] : ~sb[p];
      end
   // ==========================================
   // tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      @(posedge clock);
      q = reg_rdata;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rchk
   // one packet of n beats on port p, port number in the top data bit
   task automatic line(input int p, input int n, input logic sh, input logic fe);
      logic [31:0] d;
      for (int i = 0; i < n; i++)
      begin
         d = {p[0], 31'($urandom)};
         sq[p].push_back({fe, sh, i == n - 1, i == 0, d});
         eq[p].push_back({i == n - 1, sh, d});
      end
   endtask : line
   task automatic idle_chk();
      repeat (40) @(posedge clock);
      chk(36'(vsf_sink_model_i.q0.size()), 36'h0);
   endtask : idle_chk
   // wait for every expected word, then match per port; order within a port is kept
   task automatic drain(input logic dup);
      logic [33:0] w;
      for (int k = 0; k < 3000 && vsf_sink_model_i.q0.size() < eq[0].size() + eq[1].size();
           k++)
         @(posedge clock);
      if (vsf_sink_model_i.q0.size() < eq[0].size() + eq[1].size())
      begin
         mismatches++;
         stop_test();
      end
      while (vsf_sink_model_i.q0.size() > 0)
      begin
         w = vsf_sink_model_i.q0.pop_front();
         chk(w, eq[w[31]].pop_front());
         if (dup)
            chk(vsf_sink_model_i.q1.pop_front(), w);
      end
      chk(36'(vsf_sink_model_i.q1.size()), 36'h0);
      $display("test done at %0t, %0d checks", $time, n_tests);
   endtask : drain
   // ==========================================
   // main sequence
   initial
   begin
      logic [7:0] q;
      void'($urandom(32'hdf855969));
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rchk(vsf_pkg::VSF_FWD_OFF_ADDR, vsf_pkg::VSF_FWD_OFF_RST);
      rchk(vsf_pkg::VSF_CTRL_ADDR, vsf_pkg::VSF_CTRL_RST);
      rchk(vsf_pkg::VSF_STATUS_ADDR, 8'h00);
      rchk(8'h23, 8'h00);
      bus(1'b1, vsf_pkg::VSF_FWD_OFF_ADDR, 8'h2f, q);
      rchk(vsf_pkg::VSF_FWD_OFF_ADDR, 8'h20);
      // only port a forwarded; port b waits until switched on
      for (int i = 0; i < 4; i++)
         line(0, 1 + $urandom_range(3), 1'b0, 1'b0);
      drain(1'b0);
      line(1, 2, 1'b0, 1'b0);
      idle_chk();
      bus(1'b1, vsf_pkg::VSF_FWD_OFF_ADDR, 8'h00, q);
      drain(1'b0);
      // rotating with copy on; sink stopped until the fifo refuses
      bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'h81, q);
      stop <= 1'b1;
      for (int i = 0; i < 16; i++)
         line(i % 2, 3 + $urandom_range(2), 1'b0, 1'b0);
      repeat (100) @(posedge clock);
      chk(a_ready || b_ready, 1'b0);
      stop <= 1'b0;
      slow <= 1'b1;
      drain(1'b1);
      // basic and interleaved lockstep: port a waits for port b
      for (int m = 1; m < 3; m++)
      begin
         bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'(m << 2), q);
         line(0, 3, 1'b0, 1'b0);
         idle_chk();
         bus(1'b0, vsf_pkg::VSF_STATUS_ADDR, 8'h00, q);
         chk(q[vsf_pkg::VSF_LOST_BIT], 1'b0);
         line(1, 3, 1'b0, 1'b0);
         drain(1'b0);
      end
      // send-when-ready: lines go alone, short packets still pair
      bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'h44, q);
      line(0, 2, 1'b0, 1'b0);
      drain(1'b0);
      line(0, 1, 1'b1, 1'b0);
      idle_chk();
      line(1, 1, 1'b1, 1'b0);
      drain(1'b0);
      // concatenation ignores send-when-ready and joins both lines
      bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'h4c, q);
      line(0, 2, 1'b0, 1'b0);
      idle_chk();
      eq[0][eq[0].size() - 1][33] = 1'b0;
      line(1, 2, 1'b0, 1'b0);
      drain(1'b0);
      // one frame in lockstep, then port b falls silent past the skew limit
      bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'h04, q);
      line(0, 1, 1'b1, 1'b1);
      line(1, 1, 1'b1, 1'b1);
      drain(1'b0);
      bus(1'b0, vsf_pkg::VSF_STATUS_ADDR, 8'h00, q);
      chk(q[vsf_pkg::VSF_OK_BIT], 1'b1);
      line(0, 2, 1'b0, 1'b0);
      repeat (60) @(posedge clock);
      bus(1'b0, vsf_pkg::VSF_STATUS_ADDR, 8'h00, q);
      chk(q[vsf_pkg::VSF_LOST_BIT], 1'b1);
      line(1, 2, 1'b0, 1'b0);
      drain(1'b0);
      bus(1'b0, vsf_pkg::VSF_STATUS_ADDR, 8'h00, q);
      chk(q[vsf_pkg::VSF_LOST_BIT], 1'b0);
      bus(1'b1, vsf_pkg::VSF_CTRL_ADDR, 8'h00, q);
      rchk(vsf_pkg::VSF_STATUS_ADDR, 8'h00);
      rchk(vsf_pkg::VSF_STATUS_ADDR, 8'h00);
      stop_test();
   end
endmodule : testbench
